// ===== src/sba_attention.sv
// sba_attention: attention request decision, bus error flag and node number.
// assumes the bit-level engine reports events as single-cycle pulses on
// CLK_SYS, and that idle and strap levels arrive from outside the domain.
//
// Summary of operation
// - bus error requests attention at next idle unless a bus reset comes first
// - all parties keep watching line for attention
// - no event attention until status read or bus reset
// - bus error attention ignores status-read suppression
// - attention carries no sender identity
// - node number comes from strap pin
// - strap number loaded when leaving reset
// - event attention needs flag, idle, quiet bus
// - nack sets bus error flag, drops effects
`timescale 1ns/1ps
`default_nettype none
module sba_attention
  import sba_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic BUS_IDLE,
  input wire logic BUS_LINE,
  input wire logic ADDR_STRAP,
  input wire logic BUS_RESET,
  input wire logic XFER_NACK,
  input wire logic FN_EVENT,
  input wire logic ATN_ENABLE,
  input wire logic STATUS_READ,
  input wire logic REG_READ,
  input wire logic [5:0] REG_ADDR,
  input wire logic [SBA_NODE_W-1:0] REQ_NODE,
  output logic [SBA_REG_W-1:0] REG_RDATA,
  output logic REG_HIT,
  output logic XFER_DISCARD,
  output logic ATN_REQ,
  output logic [SBA_NODE_W-1:0] NODE_NUMBER,
  output logic BUS_ERROR_FLAG
);
  sba_core_s st_ff;
  sba_core_s nxt_st;
  logic line_sync;
  logic line_fall;
  logic idle;
  logic foreign_atn;

  //////////////////////////////////////////////////////////////////////////
  sba_watch u_watch (
    .clk_sys(CLK_SYS),
    .nrst(NRST),
    .line_in(BUS_LINE),
    .line_sync(line_sync),
    .line_fall(line_fall)
  );

  function automatic logic [SBA_NODE_W-1:0] strap_to_node(input logic s);
    strap_to_node = s ? SBA_NODE_STRAP_HI : SBA_NODE_STRAP_LO;
  endfunction : strap_to_node

  assign idle = st_ff.idle_sync[1];
  // a fall on an idle line not ours is another slave's request
  assign foreign_atn = idle & line_fall & ~st_ff.atn;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.strap_sync = {st_ff.strap_sync[0], ADDR_STRAP};
    nxt_st.idle_sync = {st_ff.idle_sync[0], BUS_IDLE};
    nxt_st.atn = 1'b0;
    case (st_ff.state)
      SBA_ST_RESET: begin
        // strap taken after release, once synchronised
        nxt_st.node_reg = SBA_NODE_RESET;
        nxt_st.node_reg[SBA_NODE_LSB +: SBA_NODE_W] =
          strap_to_node(st_ff.strap_sync[1]);
        nxt_st.state = SBA_ST_RUN;
      end
      SBA_ST_RUN: begin
        if (FN_EVENT && ATN_ENABLE) begin
          nxt_st.fn_pend = 1'b1;
        end
        if (XFER_NACK) begin
          nxt_st.err_flag = 1'b1;
          nxt_st.err_pend = 1'b1;
        end
        if (STATUS_READ || BUS_RESET) begin
          nxt_st.suppress = 1'b0;
        end
        if (STATUS_READ && !XFER_NACK) begin
          nxt_st.err_flag = 1'b0;
        end
        if (BUS_RESET && !XFER_NACK) begin
          nxt_st.err_pend = 1'b0;
        end
        if (foreign_atn) begin
          // someone else alerted the master; its scan will find ours
          nxt_st.suppress = 1'b1;
        end
        if (idle && !BUS_RESET) begin
          if (st_ff.err_pend) begin
            // error path bypasses suppression to avoid deadlock
            nxt_st.atn = 1'b1;
            nxt_st.err_pend = XFER_NACK;
            if (st_ff.fn_pend && !st_ff.suppress) begin
              nxt_st.fn_pend = 1'b0;
              nxt_st.suppress = 1'b1;
            end
          end else if (st_ff.fn_pend && !st_ff.suppress &&
                       !foreign_atn) begin
            nxt_st.atn = 1'b1;
            nxt_st.fn_pend = 1'b0;
            nxt_st.suppress = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.state = SBA_ST_RESET;
      end
    endcase
    if (!NRST) begin
      // strap keeps shifting during reset so the load sees a settled level
      nxt_st.idle_sync = 2'b00;
      nxt_st.state = SBA_ST_RESET;
      nxt_st.node_reg = SBA_NODE_RESET;
      nxt_st.err_flag = 1'b0;
      nxt_st.err_pend = 1'b0;
      nxt_st.fn_pend = 1'b0;
      nxt_st.suppress = 1'b0;
      nxt_st.atn = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    st_ff <= nxt_st;
  end

  //////////////////////////////////////////////////////////////////////////
  // answer only at our own node; other addresses stay silent so the
  // master reads 00 there
  assign REG_HIT = REG_READ && (REG_ADDR == SBA_OFS_NODE_NUMBER) &&
                   (REQ_NODE != SBA_NODE_NONE) &&
                   (REQ_NODE == st_ff.node_reg[SBA_NODE_LSB +: SBA_NODE_W]);
  assign REG_RDATA = REG_HIT ? st_ff.node_reg : SBA_NODE_RESET;
  assign XFER_DISCARD = XFER_NACK;
  assign ATN_REQ = st_ff.atn;
  assign NODE_NUMBER = st_ff.node_reg[SBA_NODE_LSB +: SBA_NODE_W];
  assign BUS_ERROR_FLAG = st_ff.err_flag;
endmodule : sba_attention
`default_nettype wire

// ===== src/sba_pkg.sv
// sba_pkg: constants for the sensor bus attention and node number logic.
// assumes a single 200 MHz system clock and synchronous active-low reset.
package sba_pkg;
  localparam int unsigned SBA_NODE_W = 3;
  localparam int unsigned SBA_REG_W = 8;
  localparam logic [5:0] SBA_OFS_NODE_NUMBER = 6'h00;
  localparam logic [7:0] SBA_NODE_RESET = 8'h00;
  localparam int unsigned SBA_NODE_LSB = 0;
  localparam logic [SBA_NODE_W-1:0] SBA_NODE_STRAP_LO = 3'h1;
  localparam logic [SBA_NODE_W-1:0] SBA_NODE_STRAP_HI = 3'h2;
  localparam logic [SBA_NODE_W-1:0] SBA_NODE_NONE = 3'h0;

  typedef enum logic [1:0] {
    SBA_ST_RESET = 2'b00,
    SBA_ST_RUN = 2'b01
  } sba_state_e;

  typedef struct packed {
    logic [1:0] strap_sync;
    logic [1:0] idle_sync;
    sba_state_e state;
    logic [SBA_REG_W-1:0] node_reg;
    logic err_flag;
    logic err_pend;
    logic fn_pend;
    logic suppress;
    logic atn;
  } sba_core_s;

  typedef struct packed {
    logic [1:0] sync;
    logic prev;
  } sba_sync_s;
endpackage : sba_pkg

// ===== src/sba_watch.sv
// sba_watch: two-flop synchroniser of the bus line with edge report.
// assumes the line level arrives asynchronously from the pin.
`timescale 1ns/1ps
`default_nettype none
module sba_watch
  import sba_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic line_in,
  output logic line_sync,
  output logic line_fall
);
  sba_sync_s st_ff;
  sba_sync_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync = {st_ff.sync[0], line_in};
    nxt_st.prev = st_ff.sync[1];
    if (!nrst) begin
      nxt_st = '{sync: 2'b11, prev: 1'b1};
    end
  end

  always_ff @(posedge clk_sys) begin
    st_ff <= nxt_st;
  end

  assign line_sync = st_ff.sync[1];
  // only the second flop feeds the edge detector
  assign line_fall = st_ff.prev & ~st_ff.sync[1];
endmodule : sba_watch
`default_nettype wire

// ===== verification/sba_attention_sva.sv
// checker for the attention, error flag and node number ports
// assumes the single CLK_SYS domain; bound onto every sba_attention
`timescale 1ns/1ps
`default_nettype none
module sba_attention_sva
  import sba_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic BUS_IDLE,
  input wire logic ADDR_STRAP,
  input wire logic BUS_RESET,
  input wire logic XFER_NACK,
  input wire logic STATUS_READ,
  input wire logic [5:0] REG_ADDR,
  input wire logic [SBA_NODE_W-1:0] REQ_NODE,
  input wire logic [SBA_REG_W-1:0] REG_RDATA,
  input wire logic REG_HIT,
  input wire logic XFER_DISCARD,
  input wire logic ATN_REQ,
  input wire logic [SBA_NODE_W-1:0] NODE_NUMBER,
  input wire logic BUS_ERROR_FLAG
);
  logic sup_ff;
  logic err_ff;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // conservative: foreign attention only adds suppression
  always_ff @(posedge CLK_SYS) begin
    sup_ff <= NRST & (ATN_REQ | (sup_ff & ~STATUS_READ & ~BUS_RESET));
    err_ff <= NRST & (XFER_NACK | (err_ff & ~ATN_REQ));
  end
  sequence err_wait;
    XFER_NACK && BUS_IDLE && !BUS_RESET
      ##1 (BUS_IDLE && !BUS_RESET && !ATN_REQ)[*3];
  endsequence
  chk_nack_drop: assert property (XFER_DISCARD == XFER_NACK)
    else $error("discard differs from nack");
  chk_nack_flag: assert property (XFER_NACK |=> BUS_ERROR_FLAG)
    else $error("error flag not set");
  chk_err_atn: assert property (not err_wait)
    else $error("no attention after bus error");
  chk_fn_supp: assert property (ATN_REQ |-> !sup_ff || err_ff)
    else $error("attention while suppressed");
  chk_atn_idle: assert property (ATN_REQ |-> $past(BUS_IDLE, 2) ||
    $past(BUS_IDLE, 3) || $past(BUS_IDLE, 4)) else $error("attention busy");
  chk_node_load: assert property ($rose(NRST) |=>
    NODE_NUMBER == ($past(ADDR_STRAP, 4) ? SBA_NODE_STRAP_HI :
    SBA_NODE_STRAP_LO)) else $error("node not from strap");
  chk_node_hold: assert property ($past(NRST, 2) && $past(NRST) |->
    $stable(NODE_NUMBER)) else $error("node number moved");
  chk_hit_addr: assert property (REG_HIT |-> REQ_NODE == NODE_NUMBER
    && REG_ADDR == SBA_OFS_NODE_NUMBER) else $error("bad read hit");
  chk_rd_data: assert property (REG_RDATA ==
    (REG_HIT ? {5'h0, NODE_NUMBER} : 8'h00)) else $error("bad read data");
endmodule : sba_attention_sva
bind sba_attention sba_attention_sva chk (.*);
`default_nettype wire

// ===== verification/sba_master_model.sv
// bus master model: scans status some cycles after any attention
// assumes one clock; line rests high on its pull-up
`timescale 1ns/1ps
`default_nettype none
module sba_master_model #(
  parameter int DLY = 40
) (
  input wire logic clk,
  input wire logic atn,
  output logic status_read,
  output logic line
);
  int cnt = 0;
  initial status_read = 1'b0;
  assign line = 1'b1;
  // no sender id, so every attention restarts the full scan
  always @(posedge clk) begin
    status_read <= (cnt == 1);
    if (atn) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : sba_master_model
`default_nettype wire

// ===== verification/sba_attention_test.sv
// bench for sba_attention with the master model
// assumes 200 MHz clock, inputs driven on falling edges
`timescale 1ns/1ps
`default_nettype none
module sba_attention_test import sba_pkg::*;;
  logic clk = 0, nrst = 0, idle = 1, strap = 0, brst = 0, nack = 0;
  logic fn = 0, en = 1, rd = 0, sread, line, hit, disc, atn, flag;
  logic [5:0] addr = 6'h00;
  logic [2:0] nq = 3'h0, node, e;
  logic [7:0] rdata;
  int n_errors = 0, cmp_count = 0, seed = 92;
  initial forever #2.5 clk = ~clk;
  sba_attention dut (.CLK_SYS(clk), .NRST(nrst), .BUS_IDLE(idle),
    .BUS_LINE(line), .ADDR_STRAP(strap), .BUS_RESET(brst),
    .XFER_NACK(nack), .FN_EVENT(fn), .ATN_ENABLE(en),
    .STATUS_READ(sread), .REG_READ(rd), .REG_ADDR(addr),
    .REQ_NODE(nq), .REG_RDATA(rdata), .REG_HIT(hit),
    .XFER_DISCARD(disc), .ATN_REQ(atn), .NODE_NUMBER(node),
    .BUS_ERROR_FLAG(flag));
  sba_master_model #(.DLY(40)) mst (.clk(clk), .atn(atn),
    .status_read(sread), .line(line));
  function automatic logic [2:0] exp_node(input logic s);
    return s ? SBA_NODE_STRAP_HI : SBA_NODE_STRAP_LO;
  endfunction : exp_node
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1;
    @(negedge clk) s = 0;
  endtask : pulse
  task automatic watch(input int n, input logic exp);
    logic seen;
    seen = 0;
    repeat (n) @(posedge clk) #1 seen |= atn;
    check(seen, exp);
  endtask : watch
  initial begin
    #20000 n_errors++;
    stop_test;
  end
  initial begin
    strap = 1'($random(seed));
    e = exp_node(strap);
    repeat (16) @(negedge clk);
    nrst = 1;
    repeat (4) @(negedge clk);
    check(node, e);
    rd = 1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) nq = i[0] ? e : 3'($random(seed));
      addr = 6'(i[1]);
      #1 check(hit, addr == 0 && nq == e);
      check(rdata, (addr == 0 && nq == e) ? 8'(e) : 8'h00);
    end
    @(negedge clk) rd = 0;
    pulse(fn);
    watch(6, 1);
    pulse(fn);
    watch(10, 0);
    pulse(nack);
    #1 check(flag, 1);
    watch(6, 1);
    repeat (100) @(negedge clk);
    pulse(fn);
    watch(6, 1);
    repeat (100) @(negedge clk) en = 0;
    pulse(fn);
    watch(10, 0);
    @(negedge clk) idle = 0;
    repeat (3) @(negedge clk);
    pulse(nack);
    pulse(brst);
    idle = 1;
    watch(10, 0);
    @(negedge clk) idle = 0;
    repeat (3) @(negedge clk);
    pulse(nack);
    repeat (2 + $unsigned($random(seed)) % 8) @(negedge clk);
    idle = 1;
    watch(8, 1);
    stop_test;
  end
endmodule : sba_attention_test
`default_nettype wire
